//--- rtl/reset_source_sequencer_defs.vh
// Constants for the reset source sequencer: option byte layout, counts, cause codes.
// Assumes inclusion by bare name from design files under rtl/.
`ifndef RESET_SOURCE_SEQUENCER_DEFS_VH
`define RESET_SOURCE_SEQUENCER_DEFS_VH

// Option byte location and fields
`define OPT_BYTE_ADDR 16'hffff
`define OPT_BYTE_ERASED 8'hff
`define OPT_LVL0_DIS_BIT 5
`define OPT_LVL1_DIS_BIT 6

// Release count of slow oscillator cycles
`define RELEASE_COUNT 6'h20

// Clock select after reset: slow oscillator divided by 8
`define CLK_SEL_SLOW_DIV8 2'h1
`define CLK_DIV_AFTER_RESET 4'h8

// Pin-held reset minimum, ns, and cycles at 8 ns
`define PIN_LOW_MIN_NS 10000
`define CLK_PERIOD_NS 8
`define PIN_LOW_MIN_CYC ((`PIN_LOW_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Reset cause codes
`define CAUSE_NONE 3'h0
`define CAUSE_PIN 3'h1
`define CAUSE_POR 3'h2
`define CAUSE_LVL0 3'h3
`define CAUSE_LVL1 3'h4

`endif

//--- rtl/slow_osc_release_counter.v
// Counts slow oscillator ticks after a reset source clears, then signals release.
// Assumes the tick is a one-cycle pulse synchronous to core_clk_i.
`timescale 1ns/1ps
`include "reset_source_sequencer_defs.vh"
module slow_osc_release_counter #(
   parameter COUNT_W = 6
) (
   // Clock and control
   input wire core_clk_i,
   input wire srst_i,
   input wire clk_en_i,
   // Hold and tick
   input wire hold_i,
   input wire slow_tick_i,
   // Release
   output wire done_o
);
   reg [COUNT_W-1:0] cnt_q;
   reg done_q;

   always @(posedge core_clk_i) begin
      if (srst_i) begin
         cnt_q <= {COUNT_W{1'b0}};
         done_q <= 1'b0;
      end else if (clk_en_i) begin
         // Hold restarts the count only while enabled, so a freeze keeps it
         if (hold_i) begin
            cnt_q <= {COUNT_W{1'b0}};
            done_q <= 1'b0;
         end else if (!done_q && slow_tick_i) begin
            // Release after 32 counts
            if (cnt_q == `RELEASE_COUNT - 6'h01) begin
               done_q <= 1'b1;
            end
            cnt_q <= cnt_q + {{(COUNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   assign done_o = done_q;
endmodule // slow_osc_release_counter

//--- rtl/reset_source_sequencer.v
// Reset source combiner and release sequencer for a small controller.
// Assumes detector levels, pin and slow tick are synchronous to core_clk_i.
//
// Notes on behaviour
// - Pin held low resets pins, CPU and registers.
// - Pin rising releases reset and fetch starts at the reset vector.
// - Every reset selects slow oscillator divided by 8 as CPU clock.
// - Reset never clears RAM; write aborted by reset leaves RAM undefined.
// - Power-on: after supply reaches threshold, 32 slow ticks then release.
// - Level-0 monitor reset stays enabled after power-on reset.
// - Level-0 low supply resets; release after 32 ticks on recovery.
// - Option bit 5 at ffff disables level-0 reset; sampled on hardware reset.
// - Option bit 6 at ffff disables level-1 reset; sampled on hardware reset.
// - Option byte is not writable by the running program.
// - Erased option byte reads all ones.
// - Level-0 variant: supply at level-1 threshold resets and restarts.
// - Level-1 monitor reset on level-0 variant keeps some registers.
// - Level-1 variant: supply above level-1 threshold, 32 ticks, then release.
// - Listed ports are inputs with drivers off while pin is low.
`timescale 1ns/1ps
`include "reset_source_sequencer_defs.vh"
module reset_source_sequencer #(
   parameter PORT_W = 24,
   parameter VECTOR_W = 20,
   parameter LVL1_VARIANT = 0
) (
   // Clock and control
   input wire core_clk_i,
   input wire srst_i,
   input wire clk_en_i,
   // External reset pin, active low
   input wire ext_reset_n_i,
   // Supply detectors: high while supply is at or below threshold
   input wire por_low_i,
   input wire lvl0_low_i,
   input wire lvl1_low_i,
   // Slow oscillator tick
   input wire slow_tick_i,
   // Monitor control bits from configuration registers
   input wire lvl0_monitor_reset_en_i,
   input wire lvl0_monitor_mode_sel_i,
   input wire lvl0_detector_en_i,
   input wire lvl1_monitor_reset_en_i,
   input wire lvl1_monitor_mode_sel_i,
   input wire lvl1_detector_en_i,
   // Flash option byte as stored
   input wire [7:0] flash_opt_byte_i,
   input wire flash_erased_i,
   // Reset vector contents
   input wire [VECTOR_W-1:0] reset_vector_i,
   // Program write attempt to the option byte
   input wire cpu_wr_i,
   input wire [15:0] cpu_addr_i,
   // RAM write in progress
   input wire ram_wr_busy_i,
   // Reset outputs
   output wire core_reset_o,
   output wire sfr_full_reset_o,
   output wire [2:0] reset_cause_o,
   // CPU start
   output wire fetch_start_o,
   output wire [VECTOR_W-1:0] fetch_addr_o,
   // Clock select
   output wire [1:0] cpu_clk_sel_o,
   output wire [3:0] cpu_clk_div_o,
   // Port driver control
   output wire [PORT_W-1:0] port_oe_allow_o,
   // Option byte view and status
   output wire [7:0] option_config_byte_o,
   output wire ram_undefined_o,
   output wire opt_wr_blocked_o
);
   ////////////////////////////////////////////////////////////////////////
   // Option byte sampling
   reg [7:0] option_config_byte_q;
   reg opt_loaded_q;
   reg pin_low_q;
   wire [7:0] opt_src;
   wire lvl0_reset_disable_opt;
   wire lvl1_reset_disable_opt;

   // Erased block reads as all ones
   assign opt_src = flash_erased_i ? `OPT_BYTE_ERASED : flash_opt_byte_i;

   always @(posedge core_clk_i) begin
      if (srst_i) begin
         option_config_byte_q <= `OPT_BYTE_ERASED;
         opt_loaded_q <= 1'b0;
      end else if (clk_en_i) begin
         // Latched only during hardware or power-on reset
         if (!ext_reset_n_i || por_low_i || !opt_loaded_q) begin
            option_config_byte_q <= opt_src;
            opt_loaded_q <= 1'b1;
         end
      end
   end

   assign lvl0_reset_disable_opt = option_config_byte_q[`OPT_LVL0_DIS_BIT];
   assign lvl1_reset_disable_opt = option_config_byte_q[`OPT_LVL1_DIS_BIT];

   // Program writes never reach the option byte
   reg opt_wr_blocked_q;
   always @(posedge core_clk_i) begin
      if (srst_i) begin
         opt_wr_blocked_q <= 1'b0;
      end else if (clk_en_i) begin
         opt_wr_blocked_q <= cpu_wr_i && (cpu_addr_i == `OPT_BYTE_ADDR);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Source qualification
   wire lvl0_armed;
   wire lvl1_armed;
   wire lvl0_src;
   wire lvl1_src;
   wire lvl1_warm;
   wire counted_hold;
   wire any_src;
   wire release_done;

   // Level-0 armed on level-0 variant only, by option and control bits
   assign lvl0_armed = (LVL1_VARIANT == 0) && !lvl0_reset_disable_opt &&
                       lvl0_monitor_reset_en_i && lvl0_monitor_mode_sel_i &&
                       lvl0_detector_en_i;
   // Level-1 armed by option and control bits
   assign lvl1_armed = !lvl1_reset_disable_opt && lvl1_monitor_reset_en_i &&
                       lvl1_monitor_mode_sel_i && lvl1_detector_en_i;

   assign lvl0_src = lvl0_armed && lvl0_low_i;
   assign lvl1_src = lvl1_armed && lvl1_low_i;

   // Level-1 on level-0 variant is a warm reset, no count
   assign lvl1_warm = (LVL1_VARIANT == 0) && lvl1_src;

   // Power-on, level-0 and level-1 variant monitor use the 32 count
   assign counted_hold = por_low_i || lvl0_src || ((LVL1_VARIANT != 0) && lvl1_src);

   slow_osc_release_counter #(
      .COUNT_W(6)
   ) u_release (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .clk_en_i(clk_en_i),
      .hold_i(counted_hold),
      .slow_tick_i(slow_tick_i),
      .done_o(release_done)
   );

   // Any active source holds, release needs all clear
   assign any_src = !ext_reset_n_i || counted_hold || !release_done || lvl1_warm;

   ////////////////////////////////////////////////////////////////////////
   // Reset state and release
   reg reset_q;
   reg full_q;
   reg [2:0] cause_q;
   reg fetch_q;
   reg [VECTOR_W-1:0] fetch_addr_q;
   reg [1:0] clk_sel_q;
   reg [3:0] clk_div_q;
   reg ram_undef_q;

   always @(posedge core_clk_i) begin
      if (srst_i) begin
         reset_q <= 1'b1;
         full_q <= 1'b1;
         cause_q <= `CAUSE_POR;
         fetch_q <= 1'b0;
         fetch_addr_q <= {VECTOR_W{1'b0}};
         clk_sel_q <= `CLK_SEL_SLOW_DIV8;
         clk_div_q <= `CLK_DIV_AFTER_RESET;
         ram_undef_q <= 1'b0;
         pin_low_q <= 1'b0;
      end else if (clk_en_i) begin
         pin_low_q <= !ext_reset_n_i;
         fetch_q <= 1'b0;
         if (any_src) begin
            reset_q <= 1'b1;
            // Any full-reset source wins over warm
            if (!ext_reset_n_i || counted_hold) begin
               full_q <= 1'b1;
            end else if (!reset_q) begin
               full_q <= 1'b0;
            end
            if (!ext_reset_n_i) begin
               cause_q <= `CAUSE_PIN;
            end else if (por_low_i) begin
               cause_q <= `CAUSE_POR;
            end else if (lvl0_src) begin
               cause_q <= `CAUSE_LVL0;
            end else if (lvl1_src) begin
               cause_q <= `CAUSE_LVL1;
            end
            // Slow oscillator div 8 forced by hardware
            clk_sel_q <= `CLK_SEL_SLOW_DIV8;
            clk_div_q <= `CLK_DIV_AFTER_RESET;
            // RAM not cleared; interrupted write flagged undefined
            if (!reset_q && ram_wr_busy_i) begin
               ram_undef_q <= 1'b1;
            end
         end else if (reset_q) begin
            // Release starts fetch at reset vector
            reset_q <= 1'b0;
            fetch_q <= 1'b1;
            fetch_addr_q <= reset_vector_i;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Port drivers off while pin low or in reset
   genvar gi;
   generate
      for (gi = 0; gi < PORT_W; gi = gi + 1) begin : g_port
         assign port_oe_allow_o[gi] = !(reset_q || pin_low_q);
      end
   endgenerate

   // Pin low timing is the external party's job; no check here
   assign core_reset_o = reset_q;
   assign sfr_full_reset_o = reset_q && full_q;
   assign reset_cause_o = cause_q;
   assign fetch_start_o = fetch_q;
   assign fetch_addr_o = fetch_addr_q;
   assign cpu_clk_sel_o = clk_sel_q;
   assign cpu_clk_div_o = clk_div_q;
   assign option_config_byte_o = option_config_byte_q;
   assign ram_undefined_o = ram_undef_q;
   assign opt_wr_blocked_o = opt_wr_blocked_q;
endmodule // reset_source_sequencer

//--- sim/reset_source_sequencer_sva.sv
// Checker for the reset source sequencer: timing of reset, fetch and status.
// Assumes clk_en_i high apart from one short freeze; bound to the top module.
`timescale 1ns/1ps
module reset_source_sequencer_sva #(
   parameter PORT_W = 24,
   parameter VECTOR_W = 20
) (
   // Clock and inputs
   input wire core_clk_i,
   input wire srst_i,
   input wire ext_reset_n_i,
   input wire por_low_i,
   input wire [VECTOR_W-1:0] reset_vector_i,
   input wire cpu_wr_i,
   input wire [15:0] cpu_addr_i,
   input wire ram_wr_busy_i,
   // Outputs watched
   input wire core_reset_o,
   input wire fetch_start_o,
   input wire [VECTOR_W-1:0] fetch_addr_o,
   input wire [1:0] cpu_clk_sel_o,
   input wire [3:0] cpu_clk_div_o,
   input wire [PORT_W-1:0] port_oe_allow_o,
   input wire ram_undefined_o,
   input wire opt_wr_blocked_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   ////////////////////////////////////////////////////////////////
   pin_hold_a: assert property (!ext_reset_n_i |=> core_reset_o)
      else $error("pin low without reset");
   port_off_a: assert property (!ext_reset_n_i |=> port_oe_allow_o == '0)
      else $error("port drivers on during pin reset");
   por_hold_a: assert property (por_low_i |=> core_reset_o)
      else $error("power-on low without reset");
   fetch_edge_a: assert property ($fell(core_reset_o) |-> fetch_start_o)
      else $error("release without fetch pulse");
   fetch_once_a: assert property (fetch_start_o |-> $fell(core_reset_o) ##1 !fetch_start_o)
      else $error("fetch pulse misplaced");
   fetch_addr_a: assert property (fetch_start_o |-> fetch_addr_o == reset_vector_i)
      else $error("fetch address not vector");
   slow_clk_a: assert property (core_reset_o |-> cpu_clk_sel_o == 2'h1 && cpu_clk_div_o == 4'h8)
      else $error("clock select not slow/8");
   opt_block_a: assert property (opt_wr_blocked_o |->
      $past(cpu_wr_i) && $past(cpu_addr_i) == 16'hffff)
      else $error("blocked flag without write");
   opt_write_a: assert property (cpu_wr_i && cpu_addr_i == 16'hffff |=> opt_wr_blocked_o)
      else $error("option write not blocked");
   ram_undef_a: assert property (!ext_reset_n_i && ram_wr_busy_i |=> ##[0:1] ram_undefined_o)
      else $error("ram not marked undefined");
   pin_cov: cover property (!ext_reset_n_i ##1 ext_reset_n_i ##1 fetch_start_o);
   por_cov: cover property ($fell(por_low_i) ##[1:300] $fell(core_reset_o));
   wr_cov: cover property (opt_wr_blocked_o);
endmodule // reset_source_sequencer_sva
bind reset_source_sequencer reset_source_sequencer_sva #(.PORT_W(PORT_W), .VECTOR_W(VECTOR_W))
   chk_u (.*);

//--- sim/ext_reset_src.sv
// Model of the external supervisor driving the active-low reset pin.
// Assumes the pin idles high through its pull-up between holds.
`timescale 1ns/1ps
module ext_reset_src (
   input wire core_clk_i,
   output logic ext_reset_n_o
);
   initial ext_reset_n_o = 1'b1;
   // Low for n cycles, then released high
   task automatic hold(input int n);
      @(posedge core_clk_i);
      #1 ext_reset_n_o = 1'b0;
      repeat (n) @(posedge core_clk_i);
      #1 ext_reset_n_o = 1'b1;
   endtask
endmodule // ext_reset_src

//--- sim/testbench.sv
// Self-checking bench for the reset source sequencer.
// Assumes a 125 MHz clock and a slow tick every fourth cycle.
`timescale 1ns/1ps
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin errors++; \
   $display("Error %s exp %h got %h", n, e, a); end end
module testbench;
   logic core_clk_i = 0, srst_i = 1, por_low_i = 1, lvl0_low_i = 0, lvl1_low_i = 0;
   logic slow_tick_i = 0, cpu_wr_i = 0, ram_wr_busy_i = 0, erased = 0, en = 1, ce = 1, ctl = 1;
   logic [1:0] tc = 0;
   logic [15:0] cpu_addr_i = 16'h0000;
   logic [7:0] opt = 8'h9f;
   logic [19:0] vec = 20'h4a5c3;
   wire pin_n, core_reset_o, sfr_full_o, fetch_start_o, ram_undef_o, wr_blk;
   wire [2:0] cause;
   wire [19:0] fetch_addr;
   wire [1:0] clk_sel;
   wire [3:0] clk_div;
   wire [23:0] oe;
   wire [7:0] opt_o;
   int errors = 0, samples_checked = 0, cycles = 0, t;
   ////////////////////////////////////////////////////////////////
   initial forever #4 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) begin
      #1 tc = tc + 2'h1;
      slow_tick_i = (tc == 2'h0);
   end
   ext_reset_src src_u (.core_clk_i(core_clk_i), .ext_reset_n_o(pin_n));
   reset_source_sequencer dut_u (.core_clk_i(core_clk_i), .srst_i(srst_i), .clk_en_i(ce),
      .ext_reset_n_i(pin_n), .por_low_i(por_low_i), .lvl0_low_i(lvl0_low_i),
      .lvl1_low_i(lvl1_low_i), .slow_tick_i(slow_tick_i), .lvl0_monitor_reset_en_i(en),
      .lvl0_monitor_mode_sel_i(en), .lvl0_detector_en_i(ctl),
      .lvl1_monitor_reset_en_i(en), .lvl1_monitor_mode_sel_i(en), .lvl1_detector_en_i(en),
      .flash_opt_byte_i(opt),
      .flash_erased_i(erased), .reset_vector_i(vec), .cpu_wr_i(cpu_wr_i),
      .cpu_addr_i(cpu_addr_i), .ram_wr_busy_i(ram_wr_busy_i), .core_reset_o(core_reset_o),
      .sfr_full_reset_o(sfr_full_o), .reset_cause_o(cause), .fetch_start_o(fetch_start_o),
      .fetch_addr_o(fetch_addr), .cpu_clk_sel_o(clk_sel), .cpu_clk_div_o(clk_div),
      .port_oe_allow_o(oe), .option_config_byte_o(opt_o), .ram_undefined_o(ram_undef_o),
      .opt_wr_blocked_o(wr_blk));
   ////////////////////////////////////////////////////////////////
   task print_verdict;
      $display("errors=%0d samples_checked=%0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         print_verdict;
      end
   end
   // Counts ticks up to release; bounded so a stuck reset ends the wait
   task wait_rel;
      t = 0;
      for (int i = 0; i < 400 && core_reset_o !== 1'b0; i++) begin
         @(posedge core_clk_i);
         t += slow_tick_i;
         #2;
      end
      `CHK("fetch", 1'b1, fetch_start_o)
      `CHK("vector", vec, fetch_addr)
   endtask
   task sync_tick;
      do @(posedge core_clk_i); while (slow_tick_i !== 1'b1);
      #2;
   endtask
   // Supply source k: 0 power-on, 1 level-0
   task supply(input int k, input logic [2:0] c);
      #1 if (k == 0) por_low_i = 1; else lvl0_low_i = 1;
      repeat (20) @(posedge core_clk_i);
      #2 `CHK("reset", 1'b1, core_reset_o)
      `CHK("cause", c, cause)
      `CHK("clk", 6'h18, {clk_sel, clk_div})
      sync_tick;
      if (k == 0) por_low_i = 0; else lvl0_low_i = 0;
      wait_rel;
      `CHK("ticks", 32, t)
   endtask
   task pin_reset;
      src_u.hold(1250);
      @(posedge core_clk_i);
      #2 `CHK("pin rel", 1'b0, core_reset_o)
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge core_clk_i);
      #1 srst_i = 0;
      supply(0, 3'h2);
      supply(1, 3'h3);
      ram_wr_busy_i = 1;
      fork
         pin_reset;
         begin
            repeat (100) @(posedge core_clk_i);
            #2 `CHK("oe", 24'h0, oe)
            `CHK("pin cause", 3'h1, cause)
            `CHK("ram", 1'b1, ram_undef_o)
            ram_wr_busy_i = 0;
         end
      join
      opt = 8'hbf;
      pin_reset;
      lvl0_low_i = 1;
      repeat (10) @(posedge core_clk_i);
      #2 `CHK("lvl0 off", 1'b0, core_reset_o)
      `CHK("opt", 8'hbf, opt_o)
      lvl0_low_i = 0;
      erased = 1;
      pin_reset;
      `CHK("erased", 8'hff, opt_o)
      lvl1_low_i = 1;
      repeat (5) @(posedge core_clk_i);
      #2 `CHK("lvl1 off", 1'b0, core_reset_o)
      lvl1_low_i = 0;
      erased = 0;
      opt = 8'h9f;
      pin_reset;
      ctl = 0;
      lvl0_low_i = 1;
      repeat (5) @(posedge core_clk_i);
      #2 `CHK("ctl off", 1'b0, core_reset_o)
      lvl0_low_i = 0;
      ctl = 1;
      cpu_wr_i = 1;
      cpu_addr_i = 16'hffff;
      @(posedge core_clk_i);
      #1 cpu_wr_i = 0;
      `CHK("wr blocked", 1'b1, wr_blk)
      repeat (3) @(posedge core_clk_i);
      #2 `CHK("opt kept", 8'h9f, opt_o)
      lvl1_low_i = 1;
      repeat (5) @(posedge core_clk_i);
      #2 `CHK("warm", 3'h4, cause)
      `CHK("sfr keep", 1'b0, sfr_full_o)
      ce = 0;
      lvl1_low_i = 0;
      repeat (5) @(posedge core_clk_i);
      #2 `CHK("freeze", 1'b1, core_reset_o)
      ce = 1;
      wait_rel;
      print_verdict;
   end
endmodule // testbench
